// ### tmh_pkg.sv
package tmh_pkg;

   // register addresses on the internal 16-bit peripheral bus
   localparam logic [15:0] TMH_ADDR_PERIOD   = 16'hFF1A;
   localparam logic [15:0] TMH_ADDR_DUTY     = 16'hFF1B;
   localparam logic [15:0] TMH_ADDR_PORT3_DIR = 16'hFF23;
   localparam logic [15:0] TMH_ADDR_PORT3_LAT = 16'hFF03;
   localparam logic [15:0] TMH_ADDR_MODE     = 16'hFF6C;

   // reset values
   localparam logic [7:0] TMH_RST_PERIOD   = 8'h00;
   localparam logic [7:0] TMH_RST_DUTY     = 8'h00;
   localparam logic [7:0] TMH_RST_MODE     = 8'h00;
   localparam logic [7:0] TMH_RST_PORT3_DIR = 8'hFF;
   localparam logic [7:0] TMH_RST_PORT3_LAT = 8'h00;
   localparam logic [7:0] TMH_CNT_ZERO     = 8'h00;
   localparam logic [7:0] TMH_CNT_ONE      = 8'h01;

   // mode register fields
   localparam int TMH_BIT_RUN     = 7;
   localparam int TMH_BIT_CKS_HI  = 6;
   localparam int TMH_BIT_CKS_LO  = 4;
   localparam int TMH_BIT_MD_HI   = 3;
   localparam int TMH_BIT_MD_LO   = 2;
   localparam int TMH_BIT_LEVEL   = 1;
   localparam int TMH_BIT_OUT_EN  = 0;
   localparam int TMH_PIN_BIT     = 0;

   // duty reload needs this many count clocks after a write
   localparam logic [1:0] TMH_DUTY_SETTLE = 2'h3;

   typedef enum logic [1:0] {
      TMH_MODE_INTERVAL = 2'b00,
      TMH_MODE_CARRIER  = 2'b01,
      TMH_MODE_PWM      = 2'b10,
      TMH_MODE_BAD      = 2'b11
   } tmh_mode_t;

   typedef enum logic [1:0] {
      TMH_ST_IDLE   = 2'b00,
      TMH_ST_MASK   = 2'b01,
      TMH_ST_PERIOD = 2'b10,
      TMH_ST_DUTY   = 2'b11
   } tmh_state_t;

endpackage : tmh_pkg

// ### tmh_prescaler.sv
`timescale 1ns/1ps
// count clock pulse generator: one-cycle tick at the selected rate
module tmh_prescaler
   import tmh_pkg::*;
#(
   parameter int DIV_W = 15
)
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // control
   input  wire logic       run,
   input  wire logic [2:0] sel,
   input  wire logic       slow_tick,
   // count clock
   output logic            tick
);

   logic [DIV_W-1:0] div_reg;
   logic [DIV_W-1:0] div_next;

   always_comb
   begin
      // divider restarts on stop so the first tick comes at most one count clock late
      div_next = run ? div_reg + {{(DIV_W-1){1'b0}}, 1'b1} : '0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         div_reg <= '0;
      else
         div_reg <= div_next;
   end

   function automatic logic wrap(input logic [DIV_W-1:0] v, input int bits);
      logic all_ones;
      all_ones = 1'b1;
      for (int i = 0; i < DIV_W; i++)
         if (i < bits)
            all_ones = all_ones & v[i];
      wrap = all_ones;
   endfunction : wrap

   always_comb
   begin
      case (sel)
         3'h0:    tick = run;
         3'h1:    tick = run & wrap(div_reg, 2);
         3'h2:    tick = run & wrap(div_reg, 4);
         3'h3:    tick = run & wrap(div_reg, 6);
         3'h4:    tick = run & wrap(div_reg, 12);
         3'h5:    tick = run & slow_tick & wrap(div_reg, 0);
         3'h6:    tick = run & slow_tick;
         default: tick = run & slow_tick;
      endcase
   end

endmodule : tmh_prescaler

// ### tmh_timer.sv
`timescale 1ns/1ps
// Behaviour
// (RQ1) interval mode: period match raises match_irq and clears counter to zero
// (RQ2) interval mode: duty compare ignored completely
// (RQ3) interval mode with output enable: output toggles on each period match
// (RQ4) interval between interrupts is period value plus one count clocks
// (RQ5) counting starts within one count clock after run enable set
// (RQ6) match_irq pulse aligned with the count clock tick
// (RQ7) run cleared: irq and output return to default levels
// (RQ8) software keeps period compare fixed while running in pwm mode
// (RQ9) pwm: period match clears counter, irqs, drives active, selects duty
// (RQ10) pwm: duty match drives inactive, selects period, no clear, no irq
// (RQ11) pwm cycle period plus one clocks, active duty plus one clocks
// (RQ12) duty write takes effect through a latch after three count clocks
// (RQ13) software rewrites duty compare before re-enabling in pwm mode
// (RQ14) software keeps duty below period and period at most FFH
// (RQ15) pwm start masks first count clock with output inactive
// (RQ16) run cleared in pwm: irq default, output inactive
// (RQ17) software clears pin direction and latch bits to route the output
// (RQ18) direction bit 0 drives pin, 1 releases it; reset value FFH
// (RQ19) run cleared stops and zeroes counter; set allows counting
// (RQ20) default level bit chooses resting output level
// (RQ21) counter increments by one per tick, wraps only on compare clear
module tmh_timer
   import tmh_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register access
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   // low speed clock tick for the slow count clock choices
   input  wire logic        slow_tick,
   // pin and event
   output logic             timer_out_pin,
   output logic             timer_out_oe,
   output logic             match_irq
);

   logic [7:0]  mode_reg, mode_next;
   logic [7:0]  period_reg, period_next;
   logic [7:0]  duty_reg, duty_next;
   logic [7:0]  duty_buf_reg, duty_buf_next;
   logic        duty_pend_reg, duty_pend_next;
   logic [1:0]  settle_reg, settle_next;
   logic [7:0]  dir_reg, dir_next;
   logic [7:0]  lat_reg, lat_next;
   logic [7:0]  cnt_reg, cnt_next;
   logic        out_reg, out_next;
   logic        irq_reg, irq_next;
   logic [7:0]  rdata_next;
   tmh_state_t  st_reg, st_next;

   logic        run;
   logic        tick;
   logic        lvl;
   tmh_mode_t   mode;

   assign run  = mode_reg[TMH_BIT_RUN];
   assign lvl  = mode_reg[TMH_BIT_LEVEL];
   assign mode = tmh_mode_t'(mode_reg[TMH_BIT_MD_HI:TMH_BIT_MD_LO]);

   tmh_prescaler u_pre (
      .clk       (clk),
      .rst       (rst),
      .run       (run),
      .sel       (mode_reg[TMH_BIT_CKS_HI:TMH_BIT_CKS_LO]),
      .slow_tick (slow_tick),
      .tick      (tick)
   );

   function automatic logic wr_hit(input logic [15:0] a);
      wr_hit = reg_wr && (reg_addr == a);
   endfunction : wr_hit

   // register writes and duty reload latch
   always_comb
   begin
      mode_next      = mode_reg;
      period_next    = period_reg;
      duty_next      = duty_reg;
      duty_buf_next  = duty_buf_reg;
      duty_pend_next = duty_pend_reg;
      settle_next    = settle_reg;
      dir_next       = dir_reg;
      lat_next       = lat_reg;
      // while running only the run bit may change; other bits are held
      if (wr_hit(TMH_ADDR_MODE))
      begin
         if (run)
            mode_next[TMH_BIT_RUN] = reg_wdata[TMH_BIT_RUN];
         else
            mode_next = reg_wdata;
      end
      if (wr_hit(TMH_ADDR_PERIOD) && !run)
         period_next = reg_wdata;
      if (wr_hit(TMH_ADDR_PORT3_DIR))
         dir_next = reg_wdata; // RQ18
      if (wr_hit(TMH_ADDR_PORT3_LAT))
         lat_next = reg_wdata;
      if (st_reg == TMH_ST_DUTY && tick && settle_reg == TMH_DUTY_SETTLE && duty_pend_reg
          && cnt_reg == duty_reg)
      begin
         duty_next      = duty_buf_reg; // RQ12
         duty_pend_next = 1'b0;
      end
      else if (tick && duty_pend_reg && settle_reg != TMH_DUTY_SETTLE)
         settle_next = settle_reg + 2'h1;
      if (wr_hit(TMH_ADDR_DUTY))
      begin
         if (!run)
         begin
            duty_next      = reg_wdata;
            duty_pend_next = 1'b0;
         end
         else
         begin
            // a write colliding with a reload still loads the old buffer; the new value stays pending
            duty_buf_next  = reg_wdata;
            duty_pend_next = 1'b1;
            settle_next    = 2'h0; // RQ12
         end
      end
   end

   // counter, compare sequencing and output
   always_comb
   begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      out_next = out_reg;
      irq_next = 1'b0;
      if (!run)
      begin
         st_next  = TMH_ST_IDLE;
         cnt_next = TMH_CNT_ZERO; // RQ19
         out_next = 1'b0;          // RQ7 RQ16
      end
      else
      begin
         case (st_reg)
            TMH_ST_IDLE:
               st_next = (mode == TMH_MODE_PWM) ? TMH_ST_MASK : TMH_ST_PERIOD; // RQ5
            TMH_ST_MASK:
               if (tick)
                  st_next = TMH_ST_PERIOD; // RQ15
            TMH_ST_PERIOD:
               if (tick)
               begin
                  if (cnt_reg == period_reg)
                  begin
                     cnt_next = TMH_CNT_ZERO; // RQ1 RQ4 RQ9
                     irq_next = 1'b1;         // RQ6
                     if (mode == TMH_MODE_PWM)
                     begin
                        out_next = 1'b1; // RQ9 RQ11
                        st_next  = TMH_ST_DUTY;
                     end
                     else if (mode_reg[TMH_BIT_OUT_EN])
                        out_next = ~out_reg; // RQ3
                  end
                  else
                     cnt_next = cnt_reg + TMH_CNT_ONE; // RQ21 RQ2
               end
            TMH_ST_DUTY:
               if (tick)
               begin
                  cnt_next = cnt_reg + TMH_CNT_ONE; // RQ21
                  if (cnt_reg == duty_reg)
                  begin
                     out_next = 1'b0;           // RQ10 RQ11
                     st_next  = TMH_ST_PERIOD;
                  end
               end
            default:
               st_next = TMH_ST_IDLE;
         endcase
      end
   end

   always_comb
   begin
      case (reg_addr)
         TMH_ADDR_MODE:      rdata_next = mode_reg;
         TMH_ADDR_PERIOD:    rdata_next = period_reg;
         TMH_ADDR_DUTY:      rdata_next = duty_reg;
         TMH_ADDR_PORT3_DIR: rdata_next = dir_reg;
         TMH_ADDR_PORT3_LAT: rdata_next = lat_reg;
         default:            rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_reg      <= TMH_RST_MODE;
         period_reg    <= TMH_RST_PERIOD;
         duty_reg      <= TMH_RST_DUTY;
         duty_buf_reg  <= TMH_RST_DUTY;
         duty_pend_reg <= 1'b0;
         settle_reg    <= 2'h0;
         dir_reg       <= TMH_RST_PORT3_DIR; // RQ18
         lat_reg       <= TMH_RST_PORT3_LAT;
         cnt_reg       <= TMH_CNT_ZERO;
         out_reg       <= 1'b0;
         irq_reg       <= 1'b0;
         st_reg        <= TMH_ST_IDLE;
         reg_rdata     <= 8'h00;
      end
      else
      begin
         mode_reg      <= mode_next;
         period_reg    <= period_next;
         duty_reg      <= duty_next;
         duty_buf_reg  <= duty_buf_next;
         duty_pend_reg <= duty_pend_next;
         settle_reg    <= settle_next;
         dir_reg       <= dir_next;
         lat_reg       <= lat_next;
         cnt_reg       <= cnt_next;
         out_reg       <= out_next;
         irq_reg       <= irq_next;
         st_reg        <= st_next;
         reg_rdata     <= rdata_next;
      end
   end

   // latch bit must be 0 for the timer level to reach the pin; level bit sets the rest level
   assign timer_out_pin = (out_reg ^ lvl) & ~lat_reg[TMH_PIN_BIT]; // RQ20
   assign timer_out_oe  = ~dir_reg[TMH_PIN_BIT];                   // RQ18
   assign match_irq     = irq_reg;                                 // RQ7

endmodule : tmh_timer

// ### tmh_timer_asserts.sv
`timescale 1ns/1ps
module tmh_timer_asserts
   import tmh_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // register access
   input wire logic [15:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        slow_tick,
   // pin and event
   input wire logic        timer_out_pin,
   input wire logic        timer_out_oe,
   input wire logic        match_irq
);
   logic [7:0] mode_reg, mode_next, per_reg, per_next;
   logic [8:0] gap_reg, gap_next;
   logic       lat_reg, lat_next, seen_reg, seen_next;
   wire        run  = mode_reg[TMH_BIT_RUN];
   wire        fast = mode_reg[6:4] == 3'h0;
   wire        dflt = mode_reg[TMH_BIT_LEVEL] & ~lat_reg;
   // shadow copy of mode, period and latch bit 0, with the same write locks
   always_comb
   begin
      mode_next = mode_reg;
      per_next  = per_reg;
      lat_next  = lat_reg;
      if (reg_wr && reg_addr == TMH_ADDR_MODE)
         mode_next = run ? {reg_wdata[7], mode_reg[6:0]} : reg_wdata;
      if (reg_wr && reg_addr == TMH_ADDR_PERIOD && !run)
         per_next = reg_wdata;
      if (reg_wr && reg_addr == TMH_ADDR_PORT3_LAT)
         lat_next = reg_wdata[TMH_PIN_BIT];
      gap_next  = (match_irq || !run) ? 9'h000 : gap_reg + 9'h001;
      seen_next = run & (seen_reg | match_irq);
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_reg <= 8'h00;
         per_reg  <= 8'h00;
         lat_reg  <= 1'b0;
         gap_reg  <= 9'h000;
         seen_reg <= 1'b0;
      end
      else
      begin
         mode_reg <= mode_next;
         per_reg  <= per_next;
         lat_reg  <= lat_next;
         gap_reg  <= gap_next;
         seen_reg <= seen_next;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_irq_pulse; match_irq |=> !match_irq; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one cycle");
   property p_oe_dir;
      reg_wr && reg_addr == TMH_ADDR_PORT3_DIR |=> timer_out_oe == !$past(reg_wdata[0]);
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("oe not following direction");
   property p_rst_state; $fell(rst) |-> !timer_out_oe && !match_irq; endproperty
   a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
   property p_idle_no_irq; !run && !$past(run) |-> !match_irq; endproperty
   a_idle_no_irq: assert property (p_idle_no_irq) else $error("irq while stopped");
   property p_pwm_start;
      $rose(run) && mode_reg[3:2] == 2'b10 |-> (timer_out_pin == dflt) [*2];
   endproperty
   a_pwm_start: assert property (p_pwm_start) else $error("pwm start not inactive");
   property p_stop_out; $fell(run) |=> timer_out_pin == dflt && !match_irq; endproperty
   a_stop_out: assert property (p_stop_out) else $error("stop not default");
   property p_irq_gap;
      match_irq && seen_reg && fast && !mode_reg[2] |-> gap_reg == {1'b0, per_reg};
   endproperty
   a_irq_gap: assert property (p_irq_gap) else $error("irq spacing wrong");
   property p_first_irq;
      match_irq && !seen_reg && fast && mode_reg[3:2] == 2'b00
         |-> gap_reg >= {1'b0, per_reg} && gap_reg <= {1'b0, per_reg} + 9'h003;
   endproperty
   a_first_irq: assert property (p_first_irq) else $error("late first irq");
   c_irq: cover property (match_irq && seen_reg);
   c_pwm: cover property ($rose(run) && mode_reg[3:2] == 2'b10);
   c_stop: cover property ($fell(run));
endmodule : tmh_timer_asserts

bind tmh_timer tmh_timer_asserts chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slow_tick(slow_tick),
   .timer_out_pin(timer_out_pin), .timer_out_oe(timer_out_oe), .match_irq(match_irq));

// ### tmh_pin_load.sv
`timescale 1ns/1ps
module tmh_pin_load
(
   // pin side
   input  wire logic       clk,
   input  wire logic       pin,
   input  wire logic       oe,
   // observed pad
   output logic            pad,
   output logic [8:0]      edges
);
   logic last = 1'b1;
   // a released pad is pulled up, so a dead driver never reads as low
   assign pad = oe ? pin : 1'b1;
   initial edges = 9'h000;
   always @(posedge clk)
   begin
      if (pad !== last)
         edges <= edges + 9'h001;
      last <= pad;
   end
endmodule : tmh_pin_load

// ### tmh_timer_tb.sv
`timescale 1ns/1ps
module tmh_timer_tb import tmh_pkg::*;;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic        pin, oe, irq, pad;
   logic [8:0]  edges, per, hi, ed;
   logic [2:0]  sdiv = 3'h0;
   int          errors = 0, num_checks = 0;
   always #20 clk = ~clk;
   // stand-in for the low speed oscillator: one pulse every eight clocks
   always @(posedge clk) sdiv <= sdiv + 3'h1;
   tmh_timer dut_u (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rdata(rdata), .slow_tick(sdiv == 3'h7), .timer_out_pin(pin), .timer_out_oe(oe),
      .match_irq(irq));
   tmh_pin_load load_u (.clk(clk), .pin(pin), .oe(oe), .pad(pad), .edges(edges));
   task chk(string nm, logic [8:0] exp, logic [8:0] got);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task wr8(logic [15:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr8
   task rd(logic [15:0] a, logic [7:0] exp, string nm);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      @(negedge clk);
      chk(nm, {1'b0, exp}, {1'b0, rdata});
   endtask : rd
   // one full cycle from irq to irq: length, high samples, pad changes
   task measure;
      logic [8:0] e0;
      per = 9'h000; hi = 9'h000;
      while (irq !== 1'b1 && per < 9'h1F0) begin @(negedge clk); per++; end
      e0 = edges; per = 9'h000;
      do begin @(negedge clk); per++; hi += {8'h00, pad}; end
      while (irq !== 1'b1 && per < 9'h1F0);
      ed = edges - e0;
   endtask : measure
   task t_reset;
      rd(TMH_ADDR_PORT3_DIR, 8'hFF, "dir");
      rd(TMH_ADDR_MODE, 8'h00, "mode");
      rd(16'h0000, 8'h00, "unmapped");
      chk("oe", 9'h000, {8'h00, oe});
      wr8(TMH_ADDR_PORT3_DIR, 8'hFE);
      wr8(TMH_ADDR_PORT3_LAT, 8'h00);
      wr8(TMH_ADDR_MODE, 8'h02);
      @(negedge clk);
      chk("oe on", 9'h001, {8'h00, oe});
      chk("rest high", 9'h001, {8'h00, pad});
      wr8(TMH_ADDR_MODE, 8'h00);
      @(negedge clk);
      chk("rest low", 9'h000, {8'h00, pad});
      $display("reset and pin test done");
   endtask : t_reset
   task t_interval;
      wr8(TMH_ADDR_PERIOD, 8'h04);
      rd(TMH_ADDR_PERIOD, 8'h04, "period");
      wr8(TMH_ADDR_DUTY, 8'h01);
      wr8(TMH_ADDR_MODE, 8'h81);
      repeat (2)
      begin
         measure;
         chk("int period", 9'h005, per);
         chk("int toggles", 9'h001, ed);
      end
      wr8(TMH_ADDR_MODE, 8'h01);
      repeat (2) @(negedge clk);
      chk("int stop pin", 9'h000, {8'h00, pad});
      chk("int stop irq", 9'h000, {8'h00, irq});
      // divided count clock: one tick every four clocks
      wr8(TMH_ADDR_MODE, 8'h91);
      repeat (2) measure;
      chk("int div4 period", 9'h014, per);
      wr8(TMH_ADDR_MODE, 8'h11);
      // slow count clock taken from the low speed tick
      wr8(TMH_ADDR_MODE, 8'hF1);
      repeat (2) measure;
      chk("int slow period", 9'h028, per);
      wr8(TMH_ADDR_MODE, 8'h71);
      repeat (2) @(negedge clk);
      chk("int slow stop irq", 9'h000, {8'h00, irq});
      $display("interval test done");
   endtask : t_interval
   task t_pwm;
      wr8(TMH_ADDR_DUTY, 8'h01);
      wr8(TMH_ADDR_MODE, 8'h88);
      @(negedge clk);
      chk("pwm start", 9'h000, {8'h00, pad});
      measure;
      chk("pwm period", 9'h005, per);
      chk("pwm high", 9'h002, hi);
      chk("pwm edges", 9'h002, ed);
      wr8(TMH_ADDR_DUTY, 8'h02);
      repeat (3) measure;
      chk("pwm new high", 9'h003, hi);
      rd(TMH_ADDR_DUTY, 8'h02, "duty");
      wr8(TMH_ADDR_MODE, 8'h08);
      // the output register drops one clock after the run bit clears
      repeat (2) @(negedge clk);
      chk("pwm stop", 9'h000, {8'h00, pad});
      $display("pwm test done");
   endtask : t_pwm
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test
   initial
   begin
      repeat (4000) @(posedge clk);
      errors++;
      finish_test;
   end
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_interval;
      t_pwm;
      finish_test;
   end
endmodule : tmh_timer_tb
